// ---- verilog/fp_context_pkg.sv ----
/*
  Constants for the floating-point context control register bank.
  Assumes one APB slave on mclk with 32-bit data.
*/
package fp_context_pkg;
  localparam logic [11:0] FP_CONTEXT_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] FP_EVENT_OFFSET = 12'h004;
  localparam int AUTO_PRESERVE_BIT = 31;
  localparam int LAZY_ENABLE_BIT = 30;
  localparam int LAZY_LOCK_BIT = 29;
  localparam int CLEAR_RET_BIT = 28;
  localparam int CLEAR_LOCK_BIT = 27;
  localparam int TREAT_SECURE_BIT = 26;
  localparam int USAGE_READY_BIT = 10;
  localparam int LAZY_ACTIVE_BIT = 0;
  localparam logic AUTO_PRESERVE_RESET = 1'b1;
  localparam logic LAZY_ENABLE_RESET = 1'b1;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic CLEAR_RET_RESET = 1'b0;
  localparam logic TREAT_SECURE_RESET = 1'b0;
endpackage : fp_context_pkg

// ---- verilog/fp_context_control_secure.sv ----
/*
  Floating-point context control register with Secure and Non-secure views, as an APB slave.
  Assumes pprot[1] gives the security of each access (0 Secure), and core event inputs are on mclk.
  Read data stands in the access cycle and pready is always high, so no transfer has a wait state.
*/
`timescale 1ns/1ps

// Summary of operation
// [R01] - Bit 31 enables setting the context-active flag on any floating-point instruction, banked per state.
// [R02] - With that enabled, context is saved on exception entry and restored on exit.
// [R03] - Bit 30 enables lazy saving and is shared by both states.
// [R04] - A Non-secure write to bit 30 is dropped while the lazy lock is one.
// [R05] - Bit 29 locks bit 30 against Non-secure writes and is shared.
// [R06] - Bit 28 clears S0 to S15 and the status register on every exception return when context-active and not lazy-active.
// [R07] - Bit 27 makes the Non-secure view of bit 28 read-only.
// [R08] - Bit 27 reads zero and ignores writes from Non-secure state.
// [R09] - Bit 26 at zero treats floating-point registers as Non-secure, so callee-saved ones are never pushed.
// [R10] - Software may clear bit 26 when no data needs protection to cut latency.
// [R11] - Bit 10 records usage-fault readiness at frame allocation, banked per state.
// [R12] - Bit 0 shows lazy preservation active and gates clearing on return.
// [R13] - Bits 25 to 11 read zero and ignore writes.
module fp_context_control_secure (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coreSecure,
  input wire logic fpInstrExec,
  input wire logic excEntry,
  input wire logic excReturn,
  input wire logic frameAlloc,
  input wire logic usageFaultAble,
  input wire logic lazySaveActive,
  output logic fpContextActive,
  output logic saveContext,
  output logic restoreContext,
  output logic clearCallerRegs,
  output logic lazySaveEn,
  output logic pushCalleeRegs
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [1:0] autoPreserve_reg, autoPreserve_next;
  logic [1:0] usageReady_reg, usageReady_next;
  logic lazyEnable_reg, lazyEnable_next, lazyLock_reg, lazyLock_next;
  logic clearRet_reg, clearRet_next, clearLock_reg, clearLock_next;
  logic treatSecure_reg, treatSecure_next, ctxActive_reg, ctxActive_next;
  logic [31:0] rdata_next;
  logic save_next, restore_next, clear_next, push_next;
  logic access, wr, nsAcc, hit;
  logic [0:0] bank;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign nsAcc = pprot[1];
  assign hit = (paddr == fp_context_pkg::FP_CONTEXT_CONTROL_OFFSET);
  assign bank = nsAcc ? 1'b0 : 1'b1;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    autoPreserve_next = autoPreserve_reg;
    usageReady_next = usageReady_reg;
    lazyEnable_next = lazyEnable_reg;
    lazyLock_next = lazyLock_reg;
    clearRet_next = clearRet_reg;
    clearLock_next = clearLock_reg;
    treatSecure_next = treatSecure_reg;
    ctxActive_next = ctxActive_reg;
    rdata_next = 32'h0000_0000;
    if (fpInstrExec && autoPreserve_reg[coreSecure]) begin
      ctxActive_next = 1'b1; // [R01]
    end
    if (wr && hit) begin
      autoPreserve_next[bank] = pwdata[fp_context_pkg::AUTO_PRESERVE_BIT]; // [R01]
      usageReady_next[bank] = pwdata[fp_context_pkg::USAGE_READY_BIT]; // [R11]
      if (!nsAcc || !lazyLock_reg) begin
        lazyEnable_next = pwdata[fp_context_pkg::LAZY_ENABLE_BIT]; // [R04] [R03]
      end
      if (!nsAcc) begin
        lazyLock_next = pwdata[fp_context_pkg::LAZY_LOCK_BIT]; // [R05]
        clearLock_next = pwdata[fp_context_pkg::CLEAR_LOCK_BIT]; // [R08]
        treatSecure_next = pwdata[fp_context_pkg::TREAT_SECURE_BIT]; // [R09]
      end
      if (!nsAcc || !clearLock_reg) begin
        clearRet_next = pwdata[fp_context_pkg::CLEAR_RET_BIT]; // [R07]
      end
    end
    // Capture from the core follows the bus write, so it wins when both fall in one cycle.
    if (frameAlloc) begin
      usageReady_next[coreSecure] = usageFaultAble; // [R11]
    end
    // Read data is captured in the setup cycle so that it stands through the access cycle,
    // where the master takes it; a core event during the access cycle shows on the next read.
    if (psel && !penable && !pwrite && hit) begin
      rdata_next[fp_context_pkg::AUTO_PRESERVE_BIT] = autoPreserve_reg[bank];
      rdata_next[fp_context_pkg::LAZY_ENABLE_BIT] = lazyEnable_reg;
      rdata_next[fp_context_pkg::LAZY_LOCK_BIT] = lazyLock_reg; // [R05]
      rdata_next[fp_context_pkg::CLEAR_RET_BIT] = clearRet_reg;
      rdata_next[fp_context_pkg::CLEAR_LOCK_BIT] = nsAcc ? 1'b0 : clearLock_reg; // [R08]
      rdata_next[fp_context_pkg::TREAT_SECURE_BIT] = nsAcc ? 1'b0 : treatSecure_reg;
      rdata_next[fp_context_pkg::USAGE_READY_BIT] = usageReady_reg[bank]; // [R11] [R13]
      rdata_next[fp_context_pkg::LAZY_ACTIVE_BIT] = lazySaveActive; // [R12]
    end
    // Exception-side strobes; clearing needs context active and lazy idle.
    // The context-active flag is only ever set above, on fpInstrExec; only reset clears it, as no core input can.
    save_next = excEntry && ctxActive_reg; // [R02]
    restore_next = excReturn && ctxActive_reg; // [R02]
    clear_next = excReturn && clearRet_reg && ctxActive_reg && !lazySaveActive; // [R06] [R12]
    push_next = excEntry && ctxActive_reg && treatSecure_reg && coreSecure; // [R09]
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      autoPreserve_reg <= {2{fp_context_pkg::AUTO_PRESERVE_RESET}};
      usageReady_reg <= 2'h0;
      lazyEnable_reg <= fp_context_pkg::LAZY_ENABLE_RESET;
      lazyLock_reg <= fp_context_pkg::LOCK_RESET;
      clearRet_reg <= fp_context_pkg::CLEAR_RET_RESET;
      clearLock_reg <= fp_context_pkg::LOCK_RESET;
      treatSecure_reg <= fp_context_pkg::TREAT_SECURE_RESET;
      ctxActive_reg <= 1'b0;
      prdata <= 32'h0000_0000;
      saveContext <= 1'b0;
      restoreContext <= 1'b0;
      clearCallerRegs <= 1'b0;
      pushCalleeRegs <= 1'b0;
    end else begin
      autoPreserve_reg <= autoPreserve_next;
      usageReady_reg <= usageReady_next;
      lazyEnable_reg <= lazyEnable_next;
      lazyLock_reg <= lazyLock_next;
      clearRet_reg <= clearRet_next;
      clearLock_reg <= clearLock_next;
      treatSecure_reg <= treatSecure_next;
      ctxActive_reg <= ctxActive_next;
      prdata <= rdata_next;
      saveContext <= save_next;
      restoreContext <= restore_next;
      clearCallerRegs <= clear_next;
      pushCalleeRegs <= push_next;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Every transfer ends in its first access cycle, so the master never waits.
  // Only the one mapped word answers without error; its neighbours report a slave error.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      fpContextActive <= 1'b0;
      lazySaveEn <= fp_context_pkg::LAZY_ENABLE_RESET;
    end else begin
      pready <= 1'b1;
      pslverr <= psel && !penable && (paddr != fp_context_pkg::FP_CONTEXT_CONTROL_OFFSET);
      fpContextActive <= ctxActive_next;
      lazySaveEn <= lazyEnable_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ns_lazy_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && nsAcc && lazyLock_reg) |=> $stable(lazyEnable_reg)) else $error("lazy enable changed"); // [R04]
  a_ns_clear_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && nsAcc && clearLock_reg) |=> $stable(clearRet_reg)) else $error("clear bit changed"); // [R07]
  a_ns_lock_raz: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && hit && nsAcc) |=> !prdata[27] && !prdata[26]) else $error("lock not zero"); // [R08]
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    prdata[25:11] == 15'h0000 && prdata[9:1] == 9'h000) else $error("reserved set"); // [R13]
  a_clear_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (excReturn && clearRet_reg && ctxActive_reg && !lazySaveActive) |=> clearCallerRegs) else $error("no clear"); // [R06]
  a_clear_lazy: assert property (@(posedge mclk) disable iff (!reset_n)
    (excReturn && lazySaveActive) |=> !clearCallerRegs) else $error("clear while lazy"); // [R12]
  a_ctx_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (fpInstrExec && autoPreserve_reg[coreSecure]) |=> fpContextActive) else $error("ctx not set"); // [R01]
  a_ctx_save: assert property (@(posedge mclk) disable iff (!reset_n)
    (excEntry && ctxActive_reg) |=> saveContext) else $error("no save"); // [R02]
  a_push_ns: assert property (@(posedge mclk) disable iff (!reset_n)
    (excEntry && !treatSecure_reg) |=> !pushCalleeRegs) else $error("pushed"); // [R09]
  a_ufr_cap: assert property (@(posedge mclk) disable iff (!reset_n)
    frameAlloc |=> usageReady_reg[$past(coreSecure)] == $past(usageFaultAble)) else $error("ufr"); // [R11]
  c_ns_write: cover property (@(posedge mclk) wr && hit && nsAcc);
  c_clear: cover property (@(posedge mclk) clearCallerRegs);
  c_push: cover property (@(posedge mclk) pushCalleeRegs);
  a_restore_ctx: assert property (@(posedge mclk) disable iff (!reset_n)
    (excReturn && ctxActive_reg) |=> restoreContext) else $error("no restore"); // [R02]
  a_clear_ctx: assert property (@(posedge mclk) disable iff (!reset_n)
    (excReturn && !ctxActive_reg) |=> !clearCallerRegs) else $error("clear without context"); // [R06]
  a_lazy_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && !nsAcc) |=> lazyEnable_reg == $past(pwdata[30])) else $error("lazy enable not written"); // [R03]
  a_ns_lock_wi: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && nsAcc) |=> $stable(lazyLock_reg) && $stable(clearLock_reg)) else $error("lock written"); // [R05]
  a_ns_treat_wi: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && nsAcc) |=> $stable(treatSecure_reg)) else $error("treat bit written"); // [R09]
  a_lazy_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && hit) |=> prdata[0] == $past(lazySaveActive)) else $error("bit 0 wrong"); // [R12]
  a_push_secure: assert property (@(posedge mclk) disable iff (!reset_n)
    (excEntry && ctxActive_reg && treatSecure_reg && coreSecure) |=> pushCalleeRegs) else $error("no push"); // [R09]
  a_usage_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr && hit && !frameAlloc) |=> usageReady_reg[$past(bank)] == $past(pwdata[10])) else $error("ufr write"); // [R11]
  c_frame_alloc: cover property (@(posedge mclk) frameAlloc && usageFaultAble);
  c_locked_write: cover property (@(posedge mclk) wr && hit && nsAcc && lazyLock_reg);
endmodule : fp_context_control_secure

// ---- verif/testbench.sv ----
/*
  Self-checking bench for the floating-point context control register bank, with a behavioural model.
  Assumes one mclk domain, the register at byte address 0x000 and pprot[1] high for Non-secure access.
*/
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] pprot = 3'h0;
  logic [31:0] prdata, rd, r, d;
  logic pready, pslverr, err, fpContextActive, saveContext, restoreContext, clearCallerRegs, lazySaveEn, pushCalleeRegs;
  logic coreSecure = 1'b1, fpInstrExec = 1'b0, excEntry = 1'b0, excReturn = 1'b0;
  logic frameAlloc = 1'b0, usageFaultAble = 1'b0, lazySaveActive = 1'b0;
  int errors = 0, check_count = 0, cycles = 0;
  logic [31:0] seed = 32'd90275;
  logic [1:0] autoEn = 2'b11, ufr = 2'b00;
  logic lzEn = 1'b1, lzLock = 1'b0, clr = 1'b0, clrLock = 1'b0, treatSec = 1'b0, fca = 1'b0;

  fp_context_control_secure uut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
    .pready, .pslverr, .coreSecure, .fpInstrExec, .excEntry, .excReturn, .frameAlloc, .usageFaultAble,
    .lazySaveActive, .fpContextActive, .saveContext, .restoreContext, .clearCallerRegs, .lazySaveEn, .pushCalleeRegs);

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // A hang in a wait loop ends here rather than running forever.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Bits 9 to 1 are outside this model, so reads are masked with 32'hfffffc01.
  function automatic logic [31:0] expv(input logic ns);
    return {autoEn[ns], lzEn, lzLock, clr, ns ? 2'b00 : {clrLock, treatSec}, 15'h0, ufr[ns], 9'h0, lazySaveActive};
  endfunction : expv

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic ns);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic ns, input logic [31:0] dat);
    apb(1'b1, 12'h000, dat, ns);
    autoEn[ns] = dat[31];
    ufr[ns] = dat[10];
    if (!ns || !lzLock) lzEn = dat[30];
    if (!ns || !clrLock) clr = dat[28];
    if (!ns) {lzLock, clrLock, treatSec} = {dat[29], dat[27], dat[26]};
  endtask : wr

  task automatic rdchk(input logic ns);
    apb(1'b0, 12'h000, 32'h0, ns);
    cmp(rd & 32'hfffffc01, expv(ns));
  endtask : rdchk

  task automatic pulse(input logic [3:0] v);
    @(posedge mclk);
    {fpInstrExec, excEntry, excReturn, frameAlloc} <= v;
    @(posedge mclk);
    {fpInstrExec, excEntry, excReturn, frameAlloc} <= 4'h0;
    #1;
  endtask : pulse

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk(1'b0);
    rdchk(1'b1);
    apb(1'b0, 12'h004, 32'h0, 1'b0);
    cmp(err, 1'b1);
    wr(1'b1, 32'h40000000);
    coreSecure <= 1'b0;
    pulse(4'h8);
    cmp(fpContextActive, 1'b0);
    wr(1'b0, 32'hc4000000);
    wr(1'b0, 32'hc0000000);
    rdchk(1'b0);
    for (int i = 0; i < 80; i++) begin
      @(posedge mclk);
      r = rnd();
      coreSecure <= r[0];
      usageFaultAble <= r[1];
      lazySaveActive <= r[2];
      if (r[3]) begin
        #1 d = rnd();
        wr(r[4], d);
        rdchk(r[4]);
      end
      pulse(4'h1 << r[6:5]);
      case (r[6:5])
        2'd3: begin
          fca = fca | autoEn[!coreSecure];
          cmp(fpContextActive, fca);
        end
        2'd2: begin
          cmp(saveContext, fca);
          cmp(pushCalleeRegs, fca & treatSec & coreSecure);
        end
        2'd1: begin
          cmp(restoreContext, fca);
          cmp(clearCallerRegs, clr & fca & !lazySaveActive);
        end
        default: ufr[!coreSecure] = usageFaultAble;
      endcase
      cmp(lazySaveEn, lzEn);
    end
    final_report();
  end
endmodule : testbench
